// ===== verilog/adcta_pkg.sv
// adcta_pkg: shared constants of the threshold alert logic
package adcta_pkg;
   // register pointer values
   localparam logic [1:0] PTR_RESULT = 2'h0;
   localparam logic [1:0] PTR_CONFIG = 2'h1;
   localparam logic [1:0] PTR_LOW_THR = 2'h2;
   localparam logic [1:0] PTR_HIGH_THR = 2'h3;

   // values after reset
   localparam logic [15:0] CONFIG_RESET = 16'h8583;
   localparam logic [15:0] LOW_THR_RESET = 16'h8000;
   localparam logic [15:0] HIGH_THR_RESET = 16'h7FFF;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   // configuration field positions
   localparam int CFG_STATUS = 15;
   localparam int CFG_MUX_LSB = 12;
   localparam int CFG_GAIN_LSB = 9;
   localparam int CFG_MODE = 8;
   localparam int CFG_RATE_LSB = 5;
   localparam int CFG_CMODE = 4;
   localparam int CFG_POL = 3;
   localparam int CFG_LATCH = 2;
   localparam int CFG_QUE_LSB = 0;

   // queue codes
   localparam logic [1:0] QUE_ONE = 2'h0;
   localparam logic [1:0] QUE_TWO = 2'h1;
   localparam logic [1:0] QUE_FOUR = 2'h2;
   localparam logic [1:0] QUE_OFF = 2'h3;

   // ready pulse timing in continuous mode
   localparam int CLK_PERIOD_NS = 50;
   localparam int RDY_PULSE_NS = 8000;
   localparam int RDY_PULSE_CYC =
      (RDY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // conversion sequencing states, gray along idle-single-continuous
   typedef enum logic [1:0] {
      ADCTA_IDLE = 2'b00,
      ADCTA_SINGLE = 2'b01,
      ADCTA_CONT = 2'b11
   } adcta_state_t;
endpackage : adcta_pkg

// ===== verilog/adcta_alert_core.sv
// adcta_alert_core: threshold compare, queue count and latch of the alert
module adcta_alert_core #(
   parameter int WIDTH = 16
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic result_valid,
   input wire logic [WIDTH-1:0] result,
   input wire logic [WIDTH-1:0] low_threshold,
   input wire logic [WIDTH-1:0] high_threshold,
   input wire logic window_mode,
   input wire logic alert_latch_enable,
   input wire logic [1:0] alert_queue_count,
   input wire logic latch_clear,
   output logic alert_active
);
   logic [2:0] hits_q;
   logic [2:0] hits_d;
   logic active_q;
   logic active_d;
   logic [2:0] need;
   logic above;
   logic below;
   logic exceed;
   logic release_ok;
   logic enabled;

   // signed compares on raw codes
   assign above = $signed(result) > $signed(high_threshold); // RL9
   assign below = $signed(result) < $signed(low_threshold); // RL9
   assign enabled = alert_queue_count != adcta_pkg::QUE_OFF; // RL7
   // traditional counts only overshoots, window counts both sides
   assign exceed = window_mode ? (above | below) : above; // RL16
   // traditional releases under low, window once back inside
   assign release_ok = window_mode ? !(above | below) : below; // RL16 RL4
   assign need = (alert_queue_count == adcta_pkg::QUE_ONE) ? 3'h1 :
                 (alert_queue_count == adcta_pkg::QUE_TWO) ? 3'h2 :
                 3'h4; // RL8

   // successive conversion counter, saturates at the need
   always_comb begin
      hits_d = hits_q;
      if (!enabled) begin
         hits_d = 3'h0;
      end else if (result_valid) begin
         if (!exceed) begin
            hits_d = 3'h0; // RL8
         end else if (hits_q < need) begin
            hits_d = hits_q + 3'h1;
         end
      end
   end

   // assertion state; a new trip beats a clear in the same cycle
   always_comb begin
      active_d = active_q;
      if (!enabled) begin
         active_d = 1'b0;
      end else begin
         if (latch_clear) begin
            active_d = 1'b0; // RL5
         end
         if (result_valid) begin
            if (exceed && (hits_d >= need)) begin
               active_d = 1'b1; // RL8
            end else if (!alert_latch_enable && release_ok) begin
               active_d = 1'b0; // RL4
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hits_q <= 3'h0;
         active_q <= 1'b0;
      end else begin
         hits_q <= hits_d;
         active_q <= active_d;
      end
   end

   assign alert_active = active_q;
endmodule : adcta_alert_core

// ===== verilog/adcta_top.sv
// adcta_top: configuration, thresholds and alert/ready pin of the converter
// Behaviour
// [RL1] The three-bit rate field picks 8 to 860 samples/s, reset 100b.
// [RL2] Mode bit clear gives traditional comparison, set gives window.
// [RL3] Polarity bit clear makes the alert pin active low, set active high.
// [RL4] Without latching the alert releases once results come back inside.
// [RL5] With latching the alert holds until a result read or alert response.
// [RL6] An alert response is answered with the bus address, lowest wins.
// [RL7] Queue code 11b, the reset value, disables compare and floats the pin.
// [RL8] Alert asserts after 1, 2 or 4 successive out-of-bound conversions.
// [RL9] Two 16-bit two's-complement thresholds are compared digitally.
// [RL10] High MSB set with low MSB clear turns the pin into a ready signal.
// [RL11] Ready shows the status bit in single-shot, a pulse in continuous.
// [RL12] The host keeps the high threshold above the low threshold.
// [RL13] The host rewrites both thresholds whenever the gain changes.
// [RL14] Status bit reads 0 while converting and 1 when idle.
// [RL15] Operating mode bit clear is continuous, set is single-shot, reset 1.
// [RL16] Traditional trips above high and releases below low; window trips
// outside either bound.
module adcta_top #(
   parameter int WIDTH = 16,
   parameter int ADDR_W = 7
) (
   input wire logic clk,
   input wire logic arst_n,
   // register port from the serial engine, same clock
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [1:0] reg_ptr,
   input wire logic [WIDTH-1:0] reg_wdata,
   output logic [WIDTH-1:0] reg_rdata,
   // alert response request from the serial engine
   input wire logic [ADDR_W-1:0] bus_address,
   input wire logic alert_resp_req,
   input wire logic alert_resp_won,
   output logic alert_resp_ack,
   output logic [ADDR_W-1:0] alert_resp_addr,
   // conversion datapath
   input wire logic conv_done,
   input wire logic [WIDTH-1:0] conv_result,
   output logic conv_start,
   output logic conv_continuous,
   output logic [2:0] sample_rate_select,
   output logic [9:0] sample_rate_sps,
   output logic [2:0] gain_setting,
   output logic [2:0] input_mux,
   // alert/ready pin
   output logic alert_out,
   output logic alert_oe
);
   logic [WIDTH-1:0] config_q;
   logic [WIDTH-1:0] config_d;
   logic [WIDTH-1:0] low_threshold_q;
   logic [WIDTH-1:0] high_threshold_q;
   logic [WIDTH-1:0] result_q;
   logic [WIDTH-1:0] rdata_q;
   logic [WIDTH-1:0] rdata_d;
   adcta_pkg::adcta_state_t state_q;
   adcta_pkg::adcta_state_t state_d;
   logic [7:0] rdy_cnt_q;
   logic [7:0] rdy_cnt_d;
   logic start_q;
   logic start_d;
   logic [ADDR_W-1:0] resp_addr_q;
   logic resp_ack_q;

   wire wr_config = reg_wr_en && (reg_ptr == adcta_pkg::PTR_CONFIG);
   wire wr_low = reg_wr_en && (reg_ptr == adcta_pkg::PTR_LOW_THR);
   wire wr_high = reg_wr_en && (reg_ptr == adcta_pkg::PTR_HIGH_THR);
   wire rd_result = reg_rd_en && (reg_ptr == adcta_pkg::PTR_RESULT);

   // configuration fields
   wire cont_mode = !config_q[adcta_pkg::CFG_MODE]; // RL15
   wire window_mode = config_q[adcta_pkg::CFG_CMODE]; // RL2
   wire alert_polarity = config_q[adcta_pkg::CFG_POL]; // RL3
   wire alert_latch_enable = config_q[adcta_pkg::CFG_LATCH];
   wire [1:0] alert_queue_count =
      config_q[adcta_pkg::CFG_QUE_LSB +: 2];
   wire [2:0] rate_field = config_q[adcta_pkg::CFG_RATE_LSB +: 3];

   // status bit: 0 while converting, 1 idle
   wire conversion_status_bit = (state_q == adcta_pkg::ADCTA_IDLE); // RL14

   // ready signalling chosen by the threshold sign bits
   wire ready_mode = high_threshold_q[WIDTH-1] &&
                     !low_threshold_q[WIDTH-1]; // RL10
   wire comp_enabled = alert_queue_count != adcta_pkg::QUE_OFF; // RL7

   // single-shot start only counts in power-down with the status bit set
   wire ss_request = wr_config && reg_wdata[adcta_pkg::CFG_STATUS] &&
                     reg_wdata[adcta_pkg::CFG_MODE];

   // config write; status bit is never stored, it reads the state
   always_comb begin
      config_d = config_q;
      if (wr_config) begin
         config_d = reg_wdata;
      end
      config_d[adcta_pkg::CFG_STATUS] = 1'b1;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         config_q <= adcta_pkg::CONFIG_RESET;
      end else begin
         config_q <= config_d;
      end
   end

   // threshold registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         low_threshold_q <= adcta_pkg::LOW_THR_RESET;
         high_threshold_q <= adcta_pkg::HIGH_THR_RESET;
      end else begin
         if (wr_low) begin
            low_threshold_q <= reg_wdata; // RL9
         end
         if (wr_high) begin
            high_threshold_q <= reg_wdata; // RL9
         end
      end
   end

   // conversion result capture
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         result_q <= adcta_pkg::RESULT_RESET;
      end else if (conv_done) begin
         result_q <= conv_result;
      end
   end

   // conversion sequencing
   always_comb begin
      state_d = state_q;
      start_d = 1'b0;
      case (state_q)
         adcta_pkg::ADCTA_IDLE: begin
            if (cont_mode) begin
               state_d = adcta_pkg::ADCTA_CONT; // RL15
            end else if (ss_request) begin
               state_d = adcta_pkg::ADCTA_SINGLE;
               start_d = 1'b1;
            end
         end
         adcta_pkg::ADCTA_SINGLE: begin
            // writes while busy have no effect on the running conversion
            if (conv_done) begin
               state_d = cont_mode ? adcta_pkg::ADCTA_CONT
                                   : adcta_pkg::ADCTA_IDLE;
            end
         end
         adcta_pkg::ADCTA_CONT: begin
            if (!cont_mode) begin
               state_d = adcta_pkg::ADCTA_IDLE; // RL15
            end
         end
         default: begin
            state_d = adcta_pkg::ADCTA_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= adcta_pkg::ADCTA_IDLE;
         start_q <= 1'b0;
      end else begin
         state_q <= state_d;
         start_q <= start_d;
      end
   end

   // ready pulse after each continuous conversion
   always_comb begin
      rdy_cnt_d = rdy_cnt_q;
      if (conv_done && (state_q == adcta_pkg::ADCTA_CONT)) begin
         rdy_cnt_d = 8'(adcta_pkg::RDY_PULSE_CYC); // RL11
      end else if (rdy_cnt_q != 8'h00) begin
         rdy_cnt_d = rdy_cnt_q - 8'h01;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdy_cnt_q <= 8'h00;
      end else begin
         rdy_cnt_q <= rdy_cnt_d;
      end
   end

   // alert response: answer with our address while we hold the alert outside ready mode
   logic alert_active;
   wire resp_answer = alert_resp_req && alert_active && !ready_mode;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         resp_ack_q <= 1'b0;
         resp_addr_q <= '0;
      end else begin
         resp_ack_q <= resp_answer; // RL6
         if (resp_answer) begin
            resp_addr_q <= bus_address; // RL6
         end
      end
   end

   // a lost arbitration leaves the latch set, lowest address clears first
   wire latch_clear = rd_result || alert_resp_won; // RL5 RL6

   adcta_alert_core #(
      .WIDTH(WIDTH)
   ) u_core (
      .clk(clk),
      .arst_n(arst_n),
      .result_valid(conv_done && !ready_mode),
      .result(conv_result),
      .low_threshold(low_threshold_q),
      .high_threshold(high_threshold_q),
      .window_mode(window_mode),
      .alert_latch_enable(alert_latch_enable),
      .alert_queue_count(alert_queue_count),
      .latch_clear(latch_clear),
      .alert_active(alert_active)
   );

   // pin level: ready mode shows status or pulse, else the comparator
   wire ready_level = cont_mode ? (rdy_cnt_q != 8'h00)
                                : conversion_status_bit; // RL11
   wire pin_asserted = ready_mode ? ready_level : alert_active;

   // register read data, captured at the read strobe
   assign rdata_d = (reg_ptr == adcta_pkg::PTR_RESULT) ? result_q :
                    (reg_ptr == adcta_pkg::PTR_CONFIG) ?
                    {conversion_status_bit, config_q[WIDTH-2:0]} :
                    (reg_ptr == adcta_pkg::PTR_LOW_THR) ? low_threshold_q :
                    high_threshold_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= '0;
      end else if (reg_rd_en) begin
         rdata_q <= rdata_d; // RL14
      end
   end

   // rate lookup for the datapath
   always_comb begin
      case (rate_field)
         3'h0: sample_rate_sps = 10'h008; // RL1
         3'h1: sample_rate_sps = 10'h010;
         3'h2: sample_rate_sps = 10'h020;
         3'h3: sample_rate_sps = 10'h040;
         3'h4: sample_rate_sps = 10'h080;
         3'h5: sample_rate_sps = 10'h0FA;
         3'h6: sample_rate_sps = 10'h1DB;
         default: sample_rate_sps = 10'h35C; // RL1
      endcase
   end

   // outputs
   assign reg_rdata = rdata_q;
   assign conv_start = start_q;
   assign conv_continuous = cont_mode;
   assign sample_rate_select = rate_field; // RL1
   assign gain_setting = config_q[adcta_pkg::CFG_GAIN_LSB +: 3];
   assign input_mux = config_q[adcta_pkg::CFG_MUX_LSB +: 3];
   assign alert_resp_ack = resp_ack_q;
   assign alert_resp_addr = resp_addr_q;
   // polarity folds in here so ready and alert share it
   assign alert_out = alert_polarity ? pin_asserted : !pin_asserted; // RL3
   assign alert_oe = comp_enabled; // RL7
endmodule : adcta_top

// ===== testbench/adcta_top_chk.sv
// adcta_top_chk: port-level assertions for the alert/ready logic
module adcta_top_chk #(
   parameter int WIDTH = 16,
   parameter int ADDR_W = 7
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [1:0] reg_ptr,
   input wire logic [WIDTH-1:0] reg_wdata,
   input wire logic [ADDR_W-1:0] bus_address,
   input wire logic alert_resp_req,
   input wire logic alert_resp_won,
   input wire logic alert_resp_ack,
   input wire logic [ADDR_W-1:0] alert_resp_addr,
   input wire logic conv_done,
   input wire logic conv_start,
   input wire logic conv_continuous,
   input wire logic [2:0] sample_rate_select,
   input wire logic [9:0] sample_rate_sps,
   input wire logic alert_out,
   input wire logic alert_oe
);
   localparam logic [9:0] SPS [8] = '{10'h008, 10'h010, 10'h020, 10'h040,
      10'h080, 10'h0FA, 10'h1DB, 10'h35C};
   logic cause;
   // any event that may legally move the pin; continuous mode is exempt
   // because its ready pulse ends on a timer
   assign cause = conv_done | reg_wr_en | reg_rd_en | alert_resp_won |
      conv_continuous;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_start_pulse: assert property (conv_start |=> !conv_start)
      else $error("conv_start longer than one cycle");
   a_start_cause: assert property ($rose(conv_start) |-> $past(reg_wr_en
      && reg_ptr == adcta_pkg::PTR_CONFIG && reg_wdata[15]))
      else $error("conv_start without a start write");
   a_ack_pulse: assert property (alert_resp_ack |=> !alert_resp_ack)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (alert_resp_ack |-> $past(alert_resp_req))
      else $error("ack without request");
   a_ack_addr: assert property (alert_resp_ack |->
      alert_resp_addr == $past(bus_address))
      else $error("ack carries wrong address");
   a_rate_table: assert property (sample_rate_sps ==
      SPS[sample_rate_select])
      else $error("sample rate does not match field");
   a_pin_quiet: assert property ($changed(alert_out) |->
      $past(cause) || $past(cause, 2))
      else $error("pin moved without a cause");
   a_oe_hold: assert property ($changed(alert_oe) |-> $past(reg_wr_en))
      else $error("pin enable moved without a write");
endmodule : adcta_top_chk

bind adcta_top adcta_top_chk #(.WIDTH(WIDTH), .ADDR_W(ADDR_W)) u_chk (
   .clk(clk), .arst_n(arst_n), .reg_wr_en(reg_wr_en),
   .reg_rd_en(reg_rd_en), .reg_ptr(reg_ptr), .reg_wdata(reg_wdata),
   .bus_address(bus_address), .alert_resp_req(alert_resp_req),
   .alert_resp_won(alert_resp_won), .alert_resp_ack(alert_resp_ack),
   .alert_resp_addr(alert_resp_addr), .conv_done(conv_done),
   .conv_start(conv_start), .conv_continuous(conv_continuous),
   .sample_rate_select(sample_rate_select),
   .sample_rate_sps(sample_rate_sps), .alert_out(alert_out),
   .alert_oe(alert_oe));

// ===== testbench/adcta_conv_model.sv
// adcta_conv_model: conversion datapath stand-in with a fixed latency
module adcta_conv_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic conv_start,
   input wire logic conv_continuous,
   input wire logic [15:0] next_result,
   output logic conv_done,
   output logic [15:0] conv_result
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_q;
   // result toggles outside done so a stale sample never looks valid
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 4'h0;
         conv_done <= 1'b0;
         conv_result <= 16'h0000;
      end else begin
         conv_done <= (cnt_q == 4'h1);
         conv_result <= (cnt_q == 4'h1) ? next_result : ~conv_result;
         // continuous mode restarts by itself, the design never pulses start
         if (conv_start || (conv_continuous && cnt_q == 4'h0)) cnt_q <= 4'h6;
         else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
      end
   end
endmodule : adcta_conv_model

// ===== testbench/adc_threshold_alert_logic_tb_top.sv
// adc_threshold_alert_logic_tb_top: directed bench of the alert/ready logic
module adc_threshold_alert_logic_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] BASE = 16'h0580; // single-shot, gain 010, rate 100
   logic clk = 0, arst_n = 0, wr = 0, rd = 0, req = 0, won = 0;
   logic [1:0] ptr = 2'h0;
   logic [15:0] wd = 16'h0000, nxt = 16'h0000, rv, rdata, cres;
   logic [6:0] addr = 7'h2A, raddr;
   logic ack, done, start, cont, pin, oe, mid;
   logic [2:0] rsel, gn, mx;
   logic [9:0] sps;
   logic [15:0] tbl [8] = '{16'h0008, 16'h0010, 16'h0020, 16'h0040,
      16'h0080, 16'h00FA, 16'h01DB, 16'h035C};
   int fails = 0, n_checks = 0;
   adcta_top u_dut (.clk(clk), .arst_n(arst_n), .reg_wr_en(wr),
      .reg_rd_en(rd), .reg_ptr(ptr), .reg_wdata(wd), .reg_rdata(rdata),
      .bus_address(addr), .alert_resp_req(req), .alert_resp_won(won),
      .alert_resp_ack(ack), .alert_resp_addr(raddr), .conv_done(done),
      .conv_result(cres), .conv_start(start), .conv_continuous(cont),
      .sample_rate_select(rsel), .sample_rate_sps(sps), .gain_setting(gn),
      .input_mux(mx), .alert_out(pin), .alert_oe(oe));
   adcta_conv_model u_model (.clk(clk), .arst_n(arst_n), .conv_start(start),
      .conv_continuous(cont),
      .next_result(nxt), .conv_done(done), .conv_result(cres));
   initial begin
      forever #25 clk = ~clk;
   end
   function automatic logic [15:0] b(logic x);
      return {15'h0000, x};
   endfunction : b
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr_reg(logic [1:0] p, logic [15:0] d);
      @(posedge clk);
      #1 wr = 1; ptr = p; wd = d;
      @(posedge clk);
      #1 wr = 0;
   endtask : wr_reg
   task automatic rd_reg(logic [1:0] p, output logic [15:0] d);
      @(posedge clk);
      #1 rd = 1; ptr = p;
      @(posedge clk);
      #1 rd = 0;
      @(posedge clk);
      #1 d = rdata;
   endtask : rd_reg
   task automatic finish_conv();
      repeat (20) begin
         @(posedge clk);
         if (done === 1'b1) break;
      end
      repeat (2) @(posedge clk);
      #1;
   endtask : finish_conv
   // one single-shot conversion whose result the model returns
   task automatic conv(logic [15:0] v, logic [15:0] c);
      nxt = v;
      wr_reg(adcta_pkg::PTR_CONFIG, c | 16'h8000);
      finish_conv();
   endtask : conv
   // alert response: won clears, req asks for an answer
   task automatic resp(logic w);
      @(posedge clk);
      #1 if (w) won = 1; else req = 1;
      @(posedge clk);
      #1 won = 0; req = 0;
   endtask : resp
   task automatic end_of_test();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   // watchdog at 20000 cycles, far beyond the few hundred cycles the run needs
   initial begin
      #1000000 fails++;
      end_of_test();
   end
   initial begin
      int n;
      repeat (2) @(posedge clk);
      #1 arst_n = 1;
      rd_reg(adcta_pkg::PTR_CONFIG, rv);
      chk("config", rv, 16'h8583);
      rd_reg(adcta_pkg::PTR_LOW_THR, rv);
      chk("low", rv, 16'h8000);
      rd_reg(adcta_pkg::PTR_HIGH_THR, rv);
      chk("high", rv, 16'h7FFF);
      chk("oe", b(oe), 16'h0000);
      for (int r = 0; r < 8; r++) begin
         wr_reg(adcta_pkg::PTR_CONFIG, 16'h0503 | (16'(r) << 5));
         rd_reg(adcta_pkg::PTR_CONFIG, rv);
         chk("cfg", rv, 16'h8503 | (16'(r) << 5));
         chk("sps", {6'h00, sps}, tbl[r]);
      end
      // gain and mux are only stored and passed on to the datapath
      wr_reg(adcta_pkg::PTR_CONFIG, 16'h7F03);
      chk("gain mux", {10'h000, mx, gn}, 16'h003F);
      // gain moved, so both thresholds are written again
      wr_reg(adcta_pkg::PTR_LOW_THR, 16'hFF9C);
      wr_reg(adcta_pkg::PTR_HIGH_THR, 16'h0064);
      rd_reg(adcta_pkg::PTR_LOW_THR, rv);
      chk("low", rv, 16'hFF9C);
      // queue codes need 1, 2, 4 results above high, then release below
      for (int q = 0; q < 3; q++) begin
         n = 1 << q;
         conv(16'h0000, BASE | 16'(q));
         for (int k = 1; k <= n; k++) begin
            conv(16'h00C8, BASE | 16'(q));
            chk("trip", b(pin), (k == n) ? 16'h0000 : 16'h0001);
         end
         conv(16'h0000, BASE | 16'(q));
         chk("hold", b(pin), 16'h0000);
         conv(16'hFF00, BASE | 16'(q));
         chk("release", b(pin), 16'h0001);
      end
      conv(16'hFF00, BASE | 16'h0018);
      chk("window", b(pin), 16'h0001);
      conv(16'h0000, BASE | 16'h0018);
      chk("window off", b(pin), 16'h0000);
      conv(16'h00C8, BASE | 16'h0004);
      conv(16'hFF00, BASE | 16'h0004);
      chk("latched", b(pin), 16'h0000);
      resp(1'b0);
      chk("ack", b(ack), 16'h0001);
      chk("addr", {9'h000, raddr}, 16'h002A);
      resp(1'b1);
      chk("won clear", b(pin), 16'h0001);
      conv(16'h00C8, BASE | 16'h0004);
      conv(16'hFF00, BASE | 16'h0004);
      rd_reg(adcta_pkg::PTR_RESULT, rv);
      chk("result", rv, 16'hFF00);
      chk("read clear", b(pin), 16'h0001);
      resp(1'b0);
      chk("no ack", b(ack), 16'h0000);
      wr_reg(adcta_pkg::PTR_LOW_THR, 16'h0000);
      wr_reg(adcta_pkg::PTR_HIGH_THR, 16'h8000);
      nxt = 16'h1234;
      wr_reg(adcta_pkg::PTR_CONFIG, BASE | 16'h8000);
      rd_reg(adcta_pkg::PTR_CONFIG, rv);
      chk("busy", rv, BASE);
      mid = pin;
      finish_conv();
      chk("ready", b(pin), b(~mid));
      chk("ready oe", b(oe), 16'h0001);
      rd_reg(adcta_pkg::PTR_CONFIG, rv);
      chk("idle", rv, BASE | 16'h8000);
      // continuous: no pulse before the first result, then a pulse
      wr_reg(adcta_pkg::PTR_CONFIG, BASE & 16'hFEFF);
      chk("cont", b(cont), 16'h0001);
      chk("no pulse", b(pin), 16'h0001);
      finish_conv();
      chk("pulse", b(pin), 16'h0000);
      end_of_test();
   end
endmodule : adc_threshold_alert_logic_tb_top
